// ---- swr_pkg.sv ----
`default_nettype none

package swr_pkg;

	////////////////////////////////////////////////////////////////////////
	// Clock and counter sizing
	localparam int CLK_NS = 8;
	localparam int CNT_W  = 17;

	////////////////////////////////////////////////////////////////////////
	// Device side times in ns, least times rounded up to cycles
	localparam int RST_DET_STD_NS = 120000;
	localparam int RST_DET_OD_NS  = 16000;
	localparam int RST_LONG_NS    = 480000;
	localparam int PWAIT_STD_NS   = 30000;
	localparam int PWAIT_OD_NS    = 3000;
	localparam int PLOW_STD_NS    = 120000;
	localparam int PLOW_OD_NS     = 12000;
	localparam int SAMP_STD_NS    = 30000;
	localparam int SAMP_OD_NS     = 3000;
	localparam int REC_STD_NS     = 5000;
	localparam int REC_OD_NS      = 2000;

	localparam int RST_DET_STD_CYC = (RST_DET_STD_NS + CLK_NS - 1) / CLK_NS;
	localparam int RST_DET_OD_CYC  = (RST_DET_OD_NS + CLK_NS - 1) / CLK_NS;
	localparam int RST_LONG_CYC    = (RST_LONG_NS + CLK_NS - 1) / CLK_NS;
	localparam int PWAIT_STD_CYC   = (PWAIT_STD_NS + CLK_NS - 1) / CLK_NS;
	localparam int PWAIT_OD_CYC    = (PWAIT_OD_NS + CLK_NS - 1) / CLK_NS;
	localparam int PLOW_STD_CYC    = (PLOW_STD_NS + CLK_NS - 1) / CLK_NS;
	localparam int PLOW_OD_CYC     = (PLOW_OD_NS + CLK_NS - 1) / CLK_NS;
	localparam int SAMP_STD_CYC    = (SAMP_STD_NS + CLK_NS - 1) / CLK_NS;
	localparam int SAMP_OD_CYC     = (SAMP_OD_NS + CLK_NS - 1) / CLK_NS;
	localparam int REC_STD_CYC     = (REC_STD_NS + CLK_NS - 1) / CLK_NS;
	localparam int REC_OD_CYC      = (REC_OD_NS + CLK_NS - 1) / CLK_NS;

	////////////////////////////////////////////////////////////////////////
	// Master side times in ns; longest low times round down
	localparam int MRST_STD_NS  = 480000;
	localparam int MRST_OD_NS   = 70000;
	localparam int MRSTH_STD_NS = 480000;
	localparam int MRSTH_OD_NS  = 48000;
	localparam int MPS_STD_NS   = 70000;
	localparam int MPS_OD_NS    = 8000;
	localparam int W0_STD_NS    = 60000;
	localparam int W0_OD_NS     = 6000;
	localparam int W1_STD_NS    = 6000;
	localparam int W1_OD_NS     = 1000;
	localparam int MSR_STD_NS   = 13000;
	localparam int MSR_OD_NS    = 2000;
	localparam int SLOT_STD_NS  = 70000;
	localparam int SLOT_OD_NS   = 10000;

	localparam int MRST_STD_CYC  = (MRST_STD_NS + CLK_NS - 1) / CLK_NS;
	localparam int MRST_OD_CYC   = (MRST_OD_NS + CLK_NS - 1) / CLK_NS;
	localparam int MRSTH_STD_CYC = (MRSTH_STD_NS + CLK_NS - 1) / CLK_NS;
	localparam int MRSTH_OD_CYC  = (MRSTH_OD_NS + CLK_NS - 1) / CLK_NS;
	localparam int MPS_STD_CYC   = MPS_STD_NS / CLK_NS;
	localparam int MPS_OD_CYC    = MPS_OD_NS / CLK_NS;
	localparam int W0_STD_CYC    = (W0_STD_NS + CLK_NS - 1) / CLK_NS;
	localparam int W0_OD_CYC     = (W0_OD_NS + CLK_NS - 1) / CLK_NS;
	localparam int W1_STD_CYC    = W1_STD_NS / CLK_NS;
	localparam int W1_OD_CYC     = W1_OD_NS / CLK_NS;
	localparam int MSR_STD_CYC   = MSR_STD_NS / CLK_NS;
	localparam int MSR_OD_CYC    = MSR_OD_NS / CLK_NS;
	localparam int SLOT_STD_CYC  = (SLOT_STD_NS + CLK_NS - 1) / CLK_NS;
	localparam int SLOT_OD_CYC   = (SLOT_OD_NS + CLK_NS - 1) / CLK_NS;

	////////////////////////////////////////////////////////////////////////
	// ROM function codes
	localparam logic [7:0] CMD_READ     = 8'h33;
	localparam logic [7:0] CMD_MATCH    = 8'h55;
	localparam logic [7:0] CMD_SEARCH   = 8'hF0;
	localparam logic [7:0] CMD_SKIP     = 8'hCC;
	localparam logic [7:0] CMD_RESUME   = 8'hA5;
	localparam logic [7:0] CMD_OD_SKIP  = 8'h3C;
	localparam logic [7:0] CMD_OD_MATCH = 8'h69;

	// Master request kinds
	typedef enum logic [1:0] {
		OP_RESET = 2'h0,
		OP_WRITE = 2'h1,
		OP_READ  = 2'h2
	} swr_op_type;

	// Picks the standard or overdrive count at counter width
	function automatic logic [CNT_W-1:0] swr_tsel(logic od, int s, int o);
		return od ? CNT_W'(o) : CNT_W'(s);
	endfunction

endpackage

`default_nettype wire

// ---- swr_link_if.sv ----
`default_nettype none

// Open-drain line: low whenever either end enables a low drive
interface swr_link_if;
	logic dev_out;
	logic dev_oe;
	logic mst_out;
	logic mst_oe;
	logic line;

	assign line = !((dev_oe && !dev_out) || (mst_oe && !mst_out));

	modport device (input line, output dev_out, output dev_oe);
	modport master (input line, output mst_out, output mst_oe);
endinterface

`default_nettype wire

// ---- swr_device.sv ----
`default_nettype none

module swr_device
	import swr_pkg::*;
#(
	parameter int P_RST_DET_STD_CYC = RST_DET_STD_CYC,
	parameter int P_RST_LONG_CYC    = RST_LONG_CYC,
	parameter int P_PLOW_STD_CYC    = PLOW_STD_CYC
)
(
	input  wire logic        clk,
	input  wire logic        resetn,
	swr_link_if.device       link,
	input  wire logic [63:0] rom_id,
	output var  logic        overdrive_flag,
	output var  logic        resume_flag,
	output var  logic        selected
);

	////////////////////////////////////////////////////////////////////////
	// State
	typedef enum logic [4:0] {
		L_READY = 5'b0_0001,
		L_SLOT  = 5'b0_0010,
		L_PWAIT = 5'b0_0100,
		L_PRES  = 5'b0_1000,
		L_REC   = 5'b1_0000
	} swr_lnk_type;

	typedef enum logic [5:0] {
		P_CMD    = 6'b00_0001,
		P_READ   = 6'b00_0010,
		P_MATCH  = 6'b00_0100,
		P_SEARCH = 6'b00_1000,
		P_MEM    = 6'b01_0000,
		P_IDLE   = 6'b10_0000
	} swr_rom_type;

	typedef struct packed {
		swr_lnk_type      lst;
		swr_rom_type      pst;
		logic [CNT_W-1:0] cnt;
		logic [5:0]       idx;
		logic [1:0]       trip;
		logic [7:0]       sr;
		logic             s1;
		logic             s2;
		logic             valid;
		logic             rst_seen;
		logic             oe;
		logic             od;
		logic             spd;
		logic             od_prev;
		logic             ovm;
		logic             match_ok;
		logic             resume;
		logic             sel;
	} swr_dev_type;

	// Idle line after reset: no pending slot, standard speed, no selection
	localparam swr_dev_type DEV_RST = '{
		lst: L_REC, pst: P_IDLE, cnt: '0, idx: '0, trip: '0, sr: '0,
		s1: 1'b1, s2: 1'b1, default: 1'b0
	};

	swr_dev_type q;
	swr_dev_type d;

	////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb
	begin
		logic             low;
		logic             wb;
		logic             sending;
		logic             txb;
		logic [7:0]       code;
		logic [CNT_W-1:0] t_samp;
		logic [CNT_W-1:0] t_rst;
		logic [CNT_W-1:0] t_pwait;
		logic [CNT_W-1:0] t_plow;
		logic [CNT_W-1:0] t_rec;
		low     = !q.s2;
		wb      = q.s2;
		sending = (q.pst == P_READ) ||
			(q.pst == P_SEARCH && q.trip != 2'd2);
		txb     = (q.pst == P_SEARCH && q.trip == 2'd1) ?
			!rom_id[q.idx] : rom_id[q.idx];
		code    = {wb, q.sr[7:1]};
		// Slot times keep the speed of the fall, so a code that turns
		// overdrive on cannot turn its own long zero slot into a reset
		t_samp  = swr_tsel(q.spd, SAMP_STD_CYC, SAMP_OD_CYC);
		t_rst   = swr_tsel(q.spd, P_RST_DET_STD_CYC, RST_DET_OD_CYC);
		t_pwait = swr_tsel(q.od, PWAIT_STD_CYC, PWAIT_OD_CYC);
		t_plow  = swr_tsel(q.od, P_PLOW_STD_CYC, PLOW_OD_CYC);
		t_rec   = swr_tsel(q.od, REC_STD_CYC, REC_OD_CYC);
		d       = q;
		// Only the second stage is read by logic
		d.s1    = link.line;
		d.s2    = q.s1;
		// Saturate so a very long reset still classifies as long
		if (q.cnt != '1)
			d.cnt = q.cnt + 1'b1;

		unique case (q.lst)
			L_READY:
			begin
				// Fall starts the slot timer; a zero reply drives at once
				if (low)
				begin
					d.lst      = L_SLOT;
					d.cnt      = '0;
					d.valid    = 1'b1;
					d.rst_seen = 1'b0;
					d.spd      = q.od;
					d.oe       = sending && !txb;
				end
			end
			L_SLOT:
			begin
				if (q.oe && q.cnt >= t_samp - 1'b1)
					d.oe = 1'b0;
				if (low && q.cnt >= t_rst)
				begin
					d.rst_seen = 1'b1;
					d.oe       = 1'b0;
				end
				if (!low && q.rst_seen)
				begin
					// Reset released: the low lasted one cycle more than cnt
					if (q.cnt >= CNT_W'(P_RST_LONG_CYC - 1))
						d.od = 1'b0;
					d.lst  = L_PWAIT;
					d.cnt  = '0;
					d.pst  = P_CMD;
					d.idx  = '0;
					d.trip = '0;
					d.ovm  = 1'b0;
				end
				else if (!low && (!q.valid || q.cnt > t_samp))
				begin
					d.lst = L_REC;
					d.cnt = '0;
				end
				// Write sample instant fixed by the slot timer
				if (q.valid && !q.rst_seen && q.cnt == t_samp)
				begin
					unique case (q.pst)
						P_CMD:
						begin
							d.sr  = code;
							d.idx = q.idx + 1'b1;
							if (q.idx == 6'd7)
							begin
								d.idx  = '0;
								d.trip = '0;
								unique case (code)
									CMD_READ:
										d.pst = P_READ;
									CMD_MATCH:
									begin
										d.pst      = P_MATCH;
										d.match_ok = 1'b1;
									end
									CMD_SEARCH:
										d.pst = P_SEARCH;
									CMD_SKIP:
										d.pst = P_MEM;
									CMD_RESUME:
										d.pst = q.resume ? P_MEM : P_IDLE;
									CMD_OD_SKIP:
									begin
										d.od  = 1'b1;
										d.pst = P_MEM;
									end
									CMD_OD_MATCH:
									begin
										d.od_prev  = q.od;
										d.od       = 1'b1;
										d.ovm      = 1'b1;
										d.match_ok = 1'b1;
										d.pst      = P_MATCH;
									end
									default:
										d.pst = P_IDLE;
								endcase
							end
						end
						P_READ:
						begin
							d.idx = q.idx + 1'b1;
							if (q.idx == 6'd63)
								d.pst = P_MEM;
						end
						P_MATCH:
						begin
							d.idx = q.idx + 1'b1;
							if (wb != rom_id[q.idx])
								d.match_ok = 1'b0;
							if (q.idx == 6'd63)
							begin
								if (q.match_ok && wb == rom_id[q.idx])
								begin
									d.pst    = P_MEM;
									d.resume = 1'b1;
								end
								else
								begin
									d.pst    = P_IDLE;
									d.resume = 1'b0;
									if (q.ovm)
										d.od = q.od_prev;
								end
							end
						end
						P_SEARCH:
						begin
							if (q.trip != 2'd2)
								d.trip = q.trip + 1'b1;
							else if (wb != rom_id[q.idx])
							begin
								d.pst    = P_IDLE;
								d.resume = 1'b0;
							end
							else if (q.idx == 6'd63)
							begin
								d.pst    = P_MEM;
								d.resume = 1'b1;
							end
							else
							begin
								d.idx  = q.idx + 1'b1;
								d.trip = '0;
							end
						end
						P_MEM, P_IDLE:
						begin
							// Memory functions live outside this block
						end
					endcase
				end
			end
			L_PWAIT:
			begin
				if (q.cnt >= t_pwait - 1'b1)
				begin
					d.lst = L_PRES;
					d.cnt = '0;
					d.oe  = 1'b1;
				end
			end
			L_PRES:
			begin
				if (q.cnt >= t_plow - 1'b1)
				begin
					d.lst = L_REC;
					d.cnt = '0;
					d.oe  = 1'b0;
				end
			end
			L_REC:
			begin
				// A fall inside recovery is no slot, but may grow to a reset
				if (low)
				begin
					d.lst      = L_SLOT;
					d.cnt      = '0;
					d.valid    = 1'b0;
					d.spd      = q.od;
					d.rst_seen = 1'b0;
				end
				else if (q.cnt >= t_rec - 1'b1)
					d.lst = L_READY;
			end
		endcase
		d.sel = (d.pst == P_MEM);
	end

	////////////////////////////////////////////////////////////////////////
	// Registers
	always_ff @(posedge clk)
	begin
		if (!resetn)
			q <= DEV_RST;
		else
			q <= d;
	end

	// Outputs
	assign link.dev_out   = 1'b0;
	assign link.dev_oe    = q.oe;
	assign overdrive_flag = q.od;
	assign resume_flag    = q.resume;
	assign selected       = q.sel;

endmodule // swr_device

`default_nettype wire

// ---- swr_master.sv ----
`default_nettype none

module swr_master
	import swr_pkg::*;
#(
	parameter int P_MRST_STD_CYC  = MRST_STD_CYC,
	parameter int P_MRST_OD_CYC   = MRST_OD_CYC,
	parameter int P_MRSTH_STD_CYC = MRSTH_STD_CYC,
	parameter int P_MPS_STD_CYC   = MPS_STD_CYC,
	parameter int P_W0_STD_CYC    = W0_STD_CYC,
	parameter int P_SLOT_STD_CYC  = SLOT_STD_CYC
)
(
	input  wire logic       clk,
	input  wire logic       resetn,
	swr_link_if.master      link,
	input  wire logic       cmd_valid,
	input  wire swr_op_type cmd_op,
	input  wire logic       cmd_bit,
	input  wire logic       cmd_od,
	output var  logic       cmd_ready,
	output var  logic       done,
	output var  logic       rd_bit,
	output var  logic       presence
);

	////////////////////////////////////////////////////////////////////////
	// State
	typedef enum logic [2:0] {
		M_IDLE = 3'b001,
		M_LOW  = 3'b010,
		M_HIGH = 3'b100
	} swr_mst_type;

	typedef struct packed {
		swr_mst_type      st;
		swr_op_type       op;
		logic [CNT_W-1:0] cnt;
		logic [CNT_W-1:0] low_len;
		logic [CNT_W-1:0] samp;
		logic [CNT_W-1:0] fin;
		logic             s1;
		logic             s2;
		logic             oe;
		logic             ready;
		logic             done;
		logic             rd;
		logic             pres;
	} swr_mreg_type;

	localparam swr_mreg_type MST_RST = '{
		st: M_IDLE, op: OP_RESET, cnt: '0, low_len: '0, samp: '0, fin: '0,
		s1: 1'b1, s2: 1'b1, ready: 1'b1, rd: 1'b1, default: 1'b0
	};

	swr_mreg_type q;
	swr_mreg_type d;

	////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb
	begin
		d      = q;
		d.s1   = link.line;
		d.s2   = q.s1;
		d.done = 1'b0;
		d.cnt  = q.cnt + 1'b1;
		unique case (q.st)
			M_IDLE:
			begin
				d.cnt = '0;
				// Every falling edge but presence is made here
				if (cmd_valid)
				begin
					d.st    = M_LOW;
					d.op    = cmd_op;
					d.oe    = 1'b1;
					d.ready = 1'b0;
					unique case (cmd_op)
						OP_RESET:
						begin
							d.low_len = swr_tsel(cmd_od, P_MRST_STD_CYC,
								P_MRST_OD_CYC);
							d.samp = swr_tsel(cmd_od, P_MPS_STD_CYC,
								MPS_OD_CYC);
							d.fin = swr_tsel(cmd_od, P_MRSTH_STD_CYC,
								MRSTH_OD_CYC);
						end
						OP_WRITE:
						begin
							// Write one releases early, zero holds long
							d.low_len = cmd_bit ?
								swr_tsel(cmd_od, W1_STD_CYC, W1_OD_CYC) :
								swr_tsel(cmd_od, P_W0_STD_CYC, W0_OD_CYC);
							d.samp = swr_tsel(cmd_od, MSR_STD_CYC, MSR_OD_CYC);
							d.fin  = swr_tsel(cmd_od, P_SLOT_STD_CYC,
								SLOT_OD_CYC);
						end
						default:
						begin
							d.low_len = swr_tsel(cmd_od, W1_STD_CYC,
								W1_OD_CYC);
							d.samp = swr_tsel(cmd_od, MSR_STD_CYC, MSR_OD_CYC);
							d.fin  = swr_tsel(cmd_od, P_SLOT_STD_CYC,
								SLOT_OD_CYC);
						end
					endcase
				end
			end
			M_LOW:
			begin
				if (q.cnt >= q.low_len - 1'b1)
				begin
					d.st = M_HIGH;
					d.oe = 1'b0;
					// Reset times count from release, slot times from fall
					if (q.op == OP_RESET)
						d.cnt = '0;
				end
			end
			M_HIGH:
			begin
				if (q.cnt == q.samp)
				begin
					if (q.op == OP_RESET)
						d.pres = !q.s2;
					else if (q.op == OP_READ)
						d.rd = q.s2;
				end
				// Whole slot elapses before the next may start
				if (q.cnt >= q.fin - 1'b1)
				begin
					d.st    = M_IDLE;
					d.ready = 1'b1;
					d.done  = 1'b1;
				end
			end
			default:
				d = MST_RST;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Registers
	always_ff @(posedge clk)
	begin
		if (!resetn)
			q <= MST_RST;
		else
			q <= d;
	end

	assign link.mst_out = 1'b0;
	assign link.mst_oe  = q.oe;
	assign cmd_ready    = q.ready;
	assign done         = q.done;
	assign rd_bit       = q.rd;
	assign presence     = q.pres;

endmodule // swr_master

`default_nettype wire

// ---- swr_link_checker.sv ----
`default_nettype none

module swr_link_checker
	import swr_pkg::*;
#(
	parameter int P_PLOW_STD_CYC = PLOW_STD_CYC,
	parameter int P_RST_LONG_CYC = RST_LONG_CYC
)
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic dev_out,
	input wire logic dev_oe,
	input wire logic mst_out,
	input wire logic mst_oe,
	input wire logic line,
	input wire logic overdrive_flag,
	input wire logic resume_flag,
	input wire logic selected
);
	int   hold_q;
	int   low_q;
	int   high_q;
	logic pres_q;
	logic oe_q;
	logic line_q;

	////////////////////////////////////////////////////////////////////////
	// Lengths of device drive, latest low and current high on the line
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			hold_q <= 0;
			low_q  <= 0;
			high_q <= 99999;
			pres_q <= 1'b0;
			oe_q   <= 1'b0;
			line_q <= 1'b1;
		end
		else
		begin
			hold_q <= dev_oe ? hold_q + 1 : 0;
			low_q  <= !line ? (line_q ? 1 : low_q + 1) : low_q;
			high_q <= line ? (high_q < 99999 ? high_q + 1 : high_q) : 0;
			oe_q   <= dev_oe;
			line_q <= line;
			// A rise with the master idle can only be a presence pulse
			if (dev_oe && !oe_q)
				pres_q <= !mst_oe;
		end
	end

	////////////////////////////////////////////////////////////////////////
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	open_drain_a: assert property (dev_oe |-> !dev_out)
		else $error("device drove the line high");
	slot_start_a: assert property ($rose(dev_oe) && mst_oe |-> $past(mst_oe))
		else $error("device low began before the master low");
	pres_wait_a: assert property ($rose(dev_oe) && !mst_oe |-> $past(line) && $past(line, 300))
		else $error("presence started without a high wait");
	pres_len_a: assert property ($fell(dev_oe) && pres_q |-> hold_q inside {[P_PLOW_STD_CYC-2:P_PLOW_STD_CYC+2], [1498:1502]})
		else $error("presence low has the wrong length");
	read_len_a: assert property ($fell(dev_oe) && !pres_q |-> hold_q inside {[373:377], [3748:3752]})
		else $error("read zero hold has the wrong length");
	od_clear_a: assert property ($fell(overdrive_flag) |-> low_q >= P_RST_LONG_CYC - 2)
		else $error("overdrive left without a long reset");
	od_select_a: assert property ($rose(overdrive_flag) |-> !$past(selected))
		else $error("overdrive set after selection");
	resume_set_a: assert property ($rose(resume_flag) |-> ##[0:2] selected)
		else $error("resume flag set without selection");
	master_gap_a: assert property ($rose(mst_oe) |-> !dev_oe && high_q >= 250)
		else $error("master fall came inside recovery");
endmodule // swr_link_checker

`default_nettype wire

// ---- testbench.sv ----
`default_nettype none

`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
	$display("[FAIL] %0t got %b", $time, g); end end

module testbench
	import swr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// Registration number, arbitrary value
	localparam logic [63:0] ROM_ID = 64'hA5C3_0F96_1E2D_3C4B;

	logic       clk, resetn, cmd_valid, cmd_bit, cmd_od;
	logic       cmd_ready, done, rd_bit, presence;
	logic       overdrive_flag, resume_flag, selected;
	logic [63:0] rom_id;
	swr_op_type cmd_op;
	int         miscompares, comparisons;

	swr_link_if link();

	// Resets shortened; long threshold sits between the two reset lows
	swr_device #(.P_RST_LONG_CYC(10000)) u_swr_device (.clk(clk),
		.resetn(resetn), .link(link), .rom_id(rom_id),
		.overdrive_flag(overdrive_flag), .resume_flag(resume_flag),
		.selected(selected));
	swr_master #(.P_MRST_STD_CYC(16000), .P_MRST_OD_CYC(2100),
		.P_MRSTH_STD_CYC(20000)) u_swr_master (
		.clk(clk), .resetn(resetn), .link(link), .cmd_valid(cmd_valid),
		.cmd_op(cmd_op), .cmd_bit(cmd_bit), .cmd_od(cmd_od),
		.cmd_ready(cmd_ready), .done(done), .rd_bit(rd_bit),
		.presence(presence));
	swr_link_checker #(.P_RST_LONG_CYC(10000))
		u_swr_link_checker (.clk(clk), .resetn(resetn),
		.dev_out(link.dev_out), .dev_oe(link.dev_oe),
		.mst_out(link.mst_out), .mst_oe(link.mst_oe), .line(link.line),
		.overdrive_flag(overdrive_flag), .resume_flag(resume_flag),
		.selected(selected));

	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic results();
		$display("Counts: %0d miscompares, %0d comparisons", miscompares,
			comparisons);
		if (miscompares == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// One master request; done is looked at mid-cycle where it has settled
	task automatic op(input swr_op_type o, input logic b, input logic od);
		int n;
		@(posedge clk);
		cmd_op    <= o;
		cmd_bit   <= b;
		cmd_od    <= od;
		cmd_valid <= 1'b1;
		@(posedge clk);
		cmd_valid <= 1'b0;
		n = 0;
		do
		begin
			@(negedge clk);
			n++;
		end
		while (done !== 1'b1 && n < 40000);
		if (n == 40000)
		begin
			miscompares++;
			$display("[FAIL] %0t request timed out", $time);
			results();
		end
	endtask

	task automatic bus_reset(input logic od);
		op(OP_RESET, 1'b0, od);
		`CHK(presence, 1'b1)
	endtask

	task automatic send_byte(input logic [7:0] b, input logic od);
		for (int i = 0; i < 8; i++)
			op(OP_WRITE, b[i], od);
	endtask

	task automatic rd(input logic e);
		op(OP_READ, 1'b1, 1'b1);
		`CHK(rd_bit, e)
	endtask

	////////////////////////////////////////////////////////////////////////
	// Code at standard speed, then the number at overdrive speed
	task automatic t_od_match();
		bus_reset(1'b0);
		`CHK(overdrive_flag, 1'b0)
		send_byte(CMD_OD_MATCH, 1'b0);
		for (int i = 0; i < 64; i++)
			op(OP_WRITE, ROM_ID[i], 1'b1);
		`CHK(overdrive_flag, 1'b1)
		`CHK(selected, 1'b1)
		`CHK(resume_flag, 1'b1)
	endtask

	// Short reset keeps overdrive; resume flag gives direct selection
	task automatic t_resume_on();
		bus_reset(1'b1);
		`CHK(overdrive_flag, 1'b1)
		send_byte(CMD_RESUME, 1'b1);
		`CHK(selected, 1'b1)
	endtask

	// Bit 0 chosen as own value, bit 1 opposite: device must drop out
	task automatic t_search();
		bus_reset(1'b1);
		send_byte(CMD_SEARCH, 1'b1);
		for (int i = 0; i < 2; i++)
		begin
			rd(ROM_ID[i]);
			rd(!ROM_ID[i]);
			op(OP_WRITE, i ? !ROM_ID[i] : ROM_ID[i], 1'b1);
		end
		rd(1'b1);
		rd(1'b1);
		`CHK(resume_flag, 1'b0)
		`CHK(selected, 1'b0)
	endtask

	// Wrong first bit of a match leaves the device unselected; it stays in the match until bit 63
	task automatic t_match_miss();
		bus_reset(1'b1);
		send_byte(CMD_MATCH, 1'b1);
		op(OP_WRITE, !ROM_ID[0], 1'b1);
		rd(1'b1);
		`CHK(selected, 1'b0)
	endtask

	// Resume without the flag, then an unsupported code
	task automatic t_ignored();
		bus_reset(1'b1);
		send_byte(CMD_RESUME, 1'b1);
		rd(1'b1);
		`CHK(selected, 1'b0)
		bus_reset(1'b1);
		send_byte(8'h0F, 1'b1);
		rd(1'b1);
		`CHK(selected, 1'b0)
	endtask

	// Family byte comes out least significant bit first
	task automatic t_read_rom();
		bus_reset(1'b1);
		send_byte(CMD_READ, 1'b1);
		for (int i = 0; i < 8; i++)
			rd(ROM_ID[i]);
	endtask

	task automatic t_skips();
		bus_reset(1'b1);
		send_byte(CMD_SKIP, 1'b1);
		`CHK(selected, 1'b1)
		bus_reset(1'b1);
		send_byte(CMD_OD_SKIP, 1'b1);
		`CHK(selected, 1'b1)
		`CHK(overdrive_flag, 1'b1)
	endtask

	// Long reset returns standard speed and standard presence timing
	task automatic t_long_reset();
		bus_reset(1'b0);
		`CHK(overdrive_flag, 1'b0)
		`CHK(selected, 1'b0)
	endtask

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		resetn      = 1'b0;
		rom_id      = ROM_ID;
		cmd_valid   = 1'b0;
		cmd_op      = OP_RESET;
		cmd_bit     = 1'b0;
		cmd_od      = 1'b0;
		miscompares = 0;
		comparisons = 0;
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		t_od_match();
		t_resume_on();
		t_search();
		t_match_miss();
		t_ignored();
		t_read_rom();
		t_skips();
		t_long_reset();
		results();
	end
endmodule // testbench

`default_nettype wire
